/* File: rtl/preamble_matcher.sv */
`timescale 1ns/1ps
`default_nettype none
module preamble_matcher (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic enable,
	input wire logic bitIn,
	input wire logic bitValid,
	input wire logic [15:0] preambleWord,
	input wire logic [2:0] preambleLength,
	output logic match
);
	typedef struct packed {
		logic [15:0] shift;
		logic [4:0] seen;
		logic match;
	} match_state_type;

	match_state_type r;
	match_state_type rNxt;
	logic [15:0] mask;
	logic [4:0] need;

	// ----------------------------------------
	// nibble mask; zero or above three means whole word
	// ----------------------------------------
	always_comb
	begin
		case (preambleLength)
			3'h1: mask = 16'h000F;
			3'h2: mask = 16'h00FF;
			3'h3: mask = 16'h0FFF;
			default: mask = 16'hFFFF;
		endcase
		case (preambleLength)
			3'h1: need = 5'h04;
			3'h2: need = 5'h08;
			3'h3: need = 5'h0C;
			default: need = 5'h10;
		endcase
	end

	always_comb
	begin
		rNxt = r;
		rNxt.match = 1'b0;
		if (!enable)
		begin
			rNxt.seen = 5'h00;
		end
		else if (bitValid)
		begin
			// one strobe per decoded bit, so rate counts unencoded bits
			rNxt.shift = {r.shift[14:0], bitIn};
			if (r.seen != 5'h10)
			begin
				rNxt.seen = r.seen + 5'h01;
			end
			// newest bits sit low, compared against the low nibbles
			if ((rNxt.seen >= need) &&
				((rNxt.shift & mask) == (preambleWord & mask)))
			begin
				rNxt.match = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			r <= '0;
		end
		else
		begin
			r <= rNxt;
		end
	end

	assign match = r.match;
endmodule : preamble_matcher
`default_nettype wire

/* File: rtl/rx_config_polling_wakeup.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_config_polling_wakeup #(
	parameter int STEP_CYCLES = rx_wakeup_pkg::WAKE_STEP_CYCLES
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire rx_wakeup_pkg::reg_req_type regReq,
	output logic [7:0] regRdData,
	input wire logic rxBit,
	input wire logic rxBitValid,
	input wire logic [7:0] rssiLevel,
	input wire logic [7:0] freqError,
	output logic [23:0] loWord,
	output logic ifSelect400,
	output logic [9:0] channelFilterBandwidth,
	output logic fskMode,
	output logic [2:0] fskDeviation,
	output logic oscEnable,
	output logic dataOut
);
	typedef struct packed {
		logic [7:0] modCfg;
		logic [7:0] chfSel;
		logic [23:0] lo;
		logic [7:0] stateCtrl;
		logic [7:0] preamCfg;
		logic [7:0] wakeDur;
		logic [7:0] wakeRatio;
		logic [15:0] preamWord;
		logic preamFlag;
		rx_wakeup_pkg::rx_state_type state;
		logic [15:0] stepCnt;
		logic [7:0] periodStep;
		logic [7:0] waitRep;
		logic [7:0] rdData;
		logic [9:0] bandwidth;
		logic dataOut;
	} core_state_type;

	core_state_type r;
	core_state_type rNxt;
	logic hit;
	logic detecting;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// base table is for 200kHz; 400kHz doubles every entry
	function automatic logic [9:0] filterKhz(input logic [2:0] code,
		input logic wideIf);
		logic [9:0] base;
		case (code)
			3'h0: base = 10'h0AA;
			3'h1: base = 10'h03C;
			3'h2: base = 10'h01A;
			3'h3: base = 10'h00C;
			default: base = 10'h006;
		endcase
		filterKhz = wideIf ? {base[8:0], 1'b0} : base;
	endfunction : filterKhz

	// codes past the top clamp at 20.88ms
	function automatic logic [7:0] durationSteps(input logic [7:0] code);
		if (code > (rx_wakeup_pkg::DUR_MAX_STEPS -
			rx_wakeup_pkg::DUR_MIN_STEPS))
		begin
			durationSteps = rx_wakeup_pkg::DUR_MAX_STEPS;
		end
		else
		begin
			durationSteps = code + rx_wakeup_pkg::DUR_MIN_STEPS;
		end
	endfunction : durationSteps

	assign detecting = (r.state == rx_wakeup_pkg::ST_POLL_DET);

	preamble_matcher matcher (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.enable(detecting),
		.bitIn(rxBit),
		.bitValid(rxBitValid),
		.preambleWord(r.preamWord),
		.preambleLength(r.preamCfg[2:0]),
		.match(hit)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		logic periodEnd;
		logic oscOn;
		logic wakeOn;
		logic directOn;
		rNxt = r;
		periodEnd = 1'b0;
		oscOn = r.stateCtrl[rx_wakeup_pkg::OSC_EN_BIT];
		wakeOn = r.stateCtrl[rx_wakeup_pkg::WAKE_EN_BIT];
		directOn = r.stateCtrl[rx_wakeup_pkg::DIRECT_EN_BIT];
		// register writes; read-only addresses fall through untouched
		if (regReq.wr)
		begin
			if (regReq.addr == rx_wakeup_pkg::ADDR_MOD_CFG)
			begin
				rNxt.modCfg = regReq.data;
			end
			else if (regReq.addr == rx_wakeup_pkg::ADDR_CHF_SEL)
			begin
				rNxt.chfSel = regReq.data;
			end
			else if (regReq.addr == rx_wakeup_pkg::ADDR_LO_HIGH)
			begin
				rNxt.lo[23:16] = regReq.data;
			end
			else if (regReq.addr == rx_wakeup_pkg::ADDR_LO_MID)
			begin
				rNxt.lo[15:8] = regReq.data;
			end
			else if (regReq.addr == rx_wakeup_pkg::ADDR_LO_LOW)
			begin
				rNxt.lo[7:0] = regReq.data;
			end
			else if (regReq.addr == rx_wakeup_pkg::ADDR_STATE_CTRL)
			begin
				rNxt.stateCtrl = regReq.data;
			end
			else if (regReq.addr == rx_wakeup_pkg::ADDR_PREAM_CFG)
			begin
				rNxt.preamCfg = regReq.data;
			end
			else if (regReq.addr == rx_wakeup_pkg::ADDR_WAKE_DUR)
			begin
				rNxt.wakeDur = regReq.data;
			end
			else if (regReq.addr == rx_wakeup_pkg::ADDR_WAKE_RATIO)
			begin
				rNxt.wakeRatio = {1'b0, regReq.data[6:0]};
			end
			else if (regReq.addr == rx_wakeup_pkg::ADDR_PREAM_HIGH)
			begin
				rNxt.preamWord[15:8] = regReq.data;
			end
			else if (regReq.addr == rx_wakeup_pkg::ADDR_PREAM_LOW)
			begin
				rNxt.preamWord[7:0] = regReq.data;
			end
		end
		// register reads, answered from a flop one cycle later
		rNxt.rdData = 8'h00;
		if (regReq.rd)
		begin
			if (regReq.addr == rx_wakeup_pkg::ADDR_MOD_CFG)
				rNxt.rdData = r.modCfg;
			else if (regReq.addr == rx_wakeup_pkg::ADDR_CHF_SEL)
				rNxt.rdData = r.chfSel;
			else if (regReq.addr == rx_wakeup_pkg::ADDR_LO_HIGH)
				rNxt.rdData = r.lo[23:16];
			else if (regReq.addr == rx_wakeup_pkg::ADDR_LO_MID)
				rNxt.rdData = r.lo[15:8];
			else if (regReq.addr == rx_wakeup_pkg::ADDR_LO_LOW)
				rNxt.rdData = r.lo[7:0];
			else if (regReq.addr == rx_wakeup_pkg::ADDR_RSSI)
				rNxt.rdData = rssiLevel;
			else if (regReq.addr == rx_wakeup_pkg::ADDR_FREQ_ERR)
				rNxt.rdData = freqError;
			else if (regReq.addr == rx_wakeup_pkg::ADDR_INT_STAT)
			begin
				rNxt.rdData = {7'h00, r.preamFlag};
				rNxt.preamFlag = 1'b0;
			end
			else if (regReq.addr == rx_wakeup_pkg::ADDR_STATE_CTRL)
				rNxt.rdData = r.stateCtrl;
			else if (regReq.addr == rx_wakeup_pkg::ADDR_STATE_STAT)
				rNxt.rdData = {3'h0, r.state};
			else if (regReq.addr == rx_wakeup_pkg::ADDR_PREAM_CFG)
				rNxt.rdData = r.preamCfg;
			else if (regReq.addr == rx_wakeup_pkg::ADDR_WAKE_DUR)
				rNxt.rdData = r.wakeDur;
			else if (regReq.addr == rx_wakeup_pkg::ADDR_WAKE_RATIO)
				rNxt.rdData = r.wakeRatio;
			else if (regReq.addr == rx_wakeup_pkg::ADDR_PREAM_HIGH)
				rNxt.rdData = r.preamWord[15:8];
			else if (regReq.addr == rx_wakeup_pkg::ADDR_PREAM_LOW)
				rNxt.rdData = r.preamWord[7:0];
		end
		// detection wins over a same-cycle read clear
		if (hit && detecting)
		begin
			rNxt.preamFlag = 1'b1;
		end
		// ----------------------------------------
		// polling timer: detect period then (1+ratio) periods of standby
		// ----------------------------------------
		if (r.stepCnt == 16'(STEP_CYCLES - 1))
		begin
			rNxt.stepCnt = 16'h0000;
			if (r.periodStep == durationSteps(r.wakeDur) - 8'h01)
			begin
				rNxt.periodStep = 8'h00;
				periodEnd = 1'b1;
			end
			else
			begin
				rNxt.periodStep = r.periodStep + 8'h01;
			end
		end
		else
		begin
			rNxt.stepCnt = r.stepCnt + 16'h0001;
		end
		// ----------------------------------------
		// receive state machine; directed enable outranks polling
		// ----------------------------------------
		if (!oscOn || !(wakeOn || directOn))
		begin
			rNxt.state = rx_wakeup_pkg::ST_IDLE;
		end
		else if (directOn)
		begin
			rNxt.state = rx_wakeup_pkg::ST_DIRECT;
		end
		else
		begin
			case (r.state)
				rx_wakeup_pkg::ST_POLL_DET:
				begin
					if (hit)
						rNxt.state = rx_wakeup_pkg::ST_POLL_HIT;
					else if (periodEnd)
					begin
						rNxt.state = rx_wakeup_pkg::ST_POLL_WAIT;
						rNxt.waitRep = 8'h00;
					end
				end
				rx_wakeup_pkg::ST_POLL_WAIT:
				begin
					if (periodEnd)
					begin
						if (r.waitRep == r.wakeRatio)
							rNxt.state = rx_wakeup_pkg::ST_POLL_DET;
						else
							rNxt.waitRep = r.waitRep + 8'h01;
					end
				end
				rx_wakeup_pkg::ST_POLL_HIT:
					rNxt.state = rx_wakeup_pkg::ST_POLL_HIT;
				default:
					rNxt.state = rx_wakeup_pkg::ST_POLL_DET;
			endcase
		end
		// restart the period on every state change
		if (rNxt.state != r.state)
		begin
			rNxt.stepCnt = 16'h0000;
			rNxt.periodStep = 8'h00;
		end
		// ----------------------------------------
		// data line
		// ----------------------------------------
		case (rNxt.state)
			rx_wakeup_pkg::ST_DIRECT:
			begin
				if (r.state != rx_wakeup_pkg::ST_DIRECT)
					rNxt.dataOut = 1'b1;
				else if (rxBitValid)
					rNxt.dataOut = rxBit;
			end
			rx_wakeup_pkg::ST_POLL_HIT:
				rNxt.dataOut = 1'b0;
			default:
				rNxt.dataOut = 1'b1;
		endcase
		rNxt.bandwidth = filterKhz(r.chfSel[2:0],
			r.chfSel[rx_wakeup_pkg::IF_SEL_BIT]);
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			r.modCfg <= rx_wakeup_pkg::CFG_RESET;
			r.chfSel <= rx_wakeup_pkg::CFG_RESET;
			r.lo <= 24'h000000;
			r.stateCtrl <= rx_wakeup_pkg::CFG_RESET;
			r.preamCfg <= rx_wakeup_pkg::PREAMBLE_LENGTH_RESET;
			r.wakeDur <= rx_wakeup_pkg::CFG_RESET;
			r.wakeRatio <= rx_wakeup_pkg::CFG_RESET;
			r.preamWord <= 16'h0000;
			r.preamFlag <= 1'b0;
			r.state <= rx_wakeup_pkg::ST_IDLE;
			r.stepCnt <= 16'h0000;
			r.periodStep <= 8'h00;
			r.waitRep <= 8'h00;
			r.rdData <= 8'h00;
			r.bandwidth <= 10'h0AA;
			r.dataOut <= 1'b1;
		end
		else
		begin
			r <= rNxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign regRdData = r.rdData;
	assign loWord = r.lo;
	assign ifSelect400 = r.chfSel[rx_wakeup_pkg::IF_SEL_BIT];
	assign channelFilterBandwidth = r.bandwidth;
	assign fskMode = r.modCfg[rx_wakeup_pkg::FSK_SEL_BIT];
	// deviation reads as zero outside FSK so ASK paths never see it
	assign fskDeviation = fskMode ? r.modCfg[2:0] : 3'h0;
	assign oscEnable = r.stateCtrl[rx_wakeup_pkg::OSC_EN_BIT];
	assign dataOut = r.dataOut;
endmodule : rx_config_polling_wakeup
`default_nettype wire

/* File: rtl/rx_wakeup_pkg.sv */
package rx_wakeup_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_MOD_CFG = 8'h00;
	localparam logic [7:0] ADDR_CHF_SEL = 8'h02;
	localparam logic [7:0] ADDR_LO_HIGH = 8'h09;
	localparam logic [7:0] ADDR_LO_MID = 8'h0A;
	localparam logic [7:0] ADDR_LO_LOW = 8'h0B;
	localparam logic [7:0] ADDR_RSSI = 8'h10;
	localparam logic [7:0] ADDR_FREQ_ERR = 8'h11;
	localparam logic [7:0] ADDR_INT_STAT = 8'h13;
	localparam logic [7:0] ADDR_STATE_CTRL = 8'h14;
	localparam logic [7:0] ADDR_STATE_STAT = 8'h15;
	localparam logic [7:0] ADDR_PREAM_CFG = 8'h16;
	localparam logic [7:0] ADDR_WAKE_DUR = 8'h17;
	localparam logic [7:0] ADDR_WAKE_RATIO = 8'h18;
	localparam logic [7:0] ADDR_PREAM_HIGH = 8'h19;
	localparam logic [7:0] ADDR_PREAM_LOW = 8'h1A;
	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int FSK_SEL_BIT = 7;
	localparam int IF_SEL_BIT = 4;
	localparam int OSC_EN_BIT = 0;
	localparam int WAKE_EN_BIT = 1;
	localparam int DIRECT_EN_BIT = 2;
	localparam int PREAM_FLAG_BIT = 0;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] PREAMBLE_LENGTH_RESET = 8'h04;
	// ----------------------------------------
	// timing: duration step is 0.12ms, range 4..174 steps
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int WAKE_STEP_NS = 120000;
	localparam int WAKE_STEP_CYCLES = WAKE_STEP_NS / CLK_PERIOD_NS;
	localparam logic [7:0] DUR_MIN_STEPS = 8'h04;
	localparam logic [7:0] DUR_MAX_STEPS = 8'hAE;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_req_type;
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_POLL_DET = 5'b00010,
		ST_POLL_WAIT = 5'b00100,
		ST_POLL_HIT = 5'b01000,
		ST_DIRECT = 5'b10000
	} rx_state_type;
endpackage : rx_wakeup_pkg

/* File: sim/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic core_clk,
	input wire logic [7:0] regRdData,
	output var rx_wakeup_pkg::reg_req_type regReq
);
	// ----------------------------------------
	// register access, one strobe per request
	// ----------------------------------------
	initial regReq = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		#1;
		regReq = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
		@(posedge core_clk);
		#1;
		regReq = '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(posedge core_clk);
		#1;
		regReq = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
		@(posedge core_clk);
		#1;
		regReq = '0;
		q = regRdData;
	endtask : rd
	// answer the data-line interrupt as the host firmware would
	task automatic ack(output logic [7:0] q);
		rd(8'h13, q);
		if (q[0] === 1'b1)
			wr(8'h14, 8'h05);
	endtask : ack
endmodule : host_model
`default_nettype wire

/* File: sim/rx_wakeup_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_wakeup_sva #(
	parameter int STEP_CYCLES = 4
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire rx_wakeup_pkg::reg_req_type regReq,
	input wire logic [7:0] regRdData,
	input wire logic rxBit,
	input wire logic rxBitValid,
	input wire logic [7:0] rssiLevel,
	input wire logic [23:0] loWord,
	input wire logic ifSelect400,
	input wire logic [9:0] channelFilterBandwidth,
	input wire logic fskMode,
	input wire logic [2:0] fskDeviation,
	input wire logic dataOut
);
	logic directOn_r;
	logic wakeOn_r;
	logic idleNow;
	// ----------------------------------------
	// mirror of the mode the host asked for
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			directOn_r <= 1'b0;
			wakeOn_r <= 1'b0;
		end
		else if (regReq.wr && regReq.addr == 8'h14)
		begin
			directOn_r <= regReq.data[2] & regReq.data[0];
			wakeOn_r <= regReq.data[1] & regReq.data[0];
		end
	end
	assign idleNow = !directOn_r && !wakeOn_r;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	// a second write in the gap would move the bandwidth again
	sequence chfSet(logic [4:0] f);
		regReq.wr && regReq.addr == 8'h02 && regReq.data[4:0] == f
		##1 !(regReq.wr && regReq.addr == 8'h02);
	endsequence
	a_lo_high: assert property (
		regReq.wr && regReq.addr == 8'h09
		|=> loWord[23:16] == $past(regReq.data))
		else $error("lo word high byte wrong");
	a_lo_low: assert property (
		regReq.wr && regReq.addr == 8'h0B
		|=> loWord[7:0] == $past(regReq.data))
		else $error("lo word low byte wrong");
	a_if_select: assert property (
		regReq.wr && regReq.addr == 8'h02
		|=> ifSelect400 == $past(regReq.data[4]))
		else $error("if select wrong");
	a_bw_narrow: assert property (
		chfSet(5'h04) |=> channelFilterBandwidth == 10'h006)
		else $error("narrow bandwidth wrong");
	a_bw_wide: assert property (
		chfSet(5'h12) |=> channelFilterBandwidth == 10'h034)
		else $error("wide bandwidth wrong");
	a_fsk_gate: assert property (
		!fskMode |-> fskDeviation == 3'h0)
		else $error("deviation shown without fsk");
	a_rssi_read: assert property (
		regReq.rd && regReq.addr == 8'h10
		|=> regRdData == $past(rssiLevel))
		else $error("rssi readback wrong");
	a_idle_high: assert property (
		idleNow [*3] |-> dataOut)
		else $error("data line low while idle");
	a_direct_follow: assert property (
		directOn_r && $past(directOn_r) && rxBitValid
		|=> dataOut == $past(rxBit))
		else $error("directed data not following");
endmodule : rx_wakeup_sva
bind rx_config_polling_wakeup rx_wakeup_sva #(.STEP_CYCLES(STEP_CYCLES))
	chk_u (.core_clk(core_clk), .sys_rst(sys_rst), .regReq(regReq),
	.regRdData(regRdData), .rxBit(rxBit), .rxBitValid(rxBitValid),
	.rssiLevel(rssiLevel), .loWord(loWord), .ifSelect400(ifSelect400),
	.channelFilterBandwidth(channelFilterBandwidth), .fskMode(fskMode),
	.fskDeviation(fskDeviation), .dataOut(dataOut));
`default_nettype wire

/* File: sim/test_rx_config_polling_wakeup.sv */
`timescale 1ns/1ps
`default_nettype none
module test_rx_config_polling_wakeup;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic rxBit = 1'b0;
	logic rxBitValid = 1'b0;
	logic [7:0] rssiLevel = 8'hA5;
	logic [7:0] freqError = 8'h3C;
	rx_wakeup_pkg::reg_req_type regReq;
	logic [7:0] regRdData;
	logic [23:0] loWord;
	logic ifSelect400;
	logic [9:0] channelFilterBandwidth;
	logic fskMode;
	logic [2:0] fskDeviation;
	logic oscEnable;
	logic dataOut;
	logic [7:0] q;
	int fail_count = 0;
	int n_tests = 0;
	logic [9:0] bwTbl [10] = '{10'h0AA, 10'h03C, 10'h01A, 10'h00C, 10'h006,
		10'h154, 10'h078, 10'h034, 10'h018, 10'h00C};
	// ----------------------------------------
	// clock, host and device
	// ----------------------------------------
	always #25 core_clk = ~core_clk;
	host_model host_u (.core_clk(core_clk), .regRdData(regRdData),
		.regReq(regReq));
	rx_config_polling_wakeup #(.STEP_CYCLES(4)) dut_u (.core_clk(core_clk),
		.sys_rst(sys_rst), .regReq(regReq), .regRdData(regRdData),
		.rxBit(rxBit), .rxBitValid(rxBitValid), .rssiLevel(rssiLevel),
		.freqError(freqError), .loWord(loWord), .ifSelect400(ifSelect400),
		.channelFilterBandwidth(channelFilterBandwidth), .fskMode(fskMode),
		.fskDeviation(fskDeviation), .oscEnable(oscEnable),
		.dataOut(dataOut));
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic settle;
		@(posedge core_clk);
		#1;
	endtask : settle
	// the line is flipped between strobes so nothing rides on a stale level
	task automatic sendBit(input logic b);
		settle;
		rxBit = b;
		rxBitValid = 1'b1;
		settle;
		rxBitValid = 1'b0;
		rxBit = ~b;
	endtask : sendBit
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	initial
	begin
		repeat (20000) @(posedge core_clk);
		fail_count++;
		test_done;
	end
	initial
	begin
		repeat (3) settle;
		sys_rst = 1'b0;
		chk(dataOut, 1'b1);
		chk(channelFilterBandwidth, 10'h0AA);
		host_u.wr(8'h14, 8'h01);
		chk(oscEnable, 1'b1);
		host_u.wr(8'h09, 8'h12);
		host_u.wr(8'h0A, 8'h34);
		host_u.wr(8'h0B, 8'h56);
		chk(loWord, 24'h123456);
		for (int i = 0; i < 10; i++)
		begin
			host_u.wr(8'h02, {3'h0, i > 4, 1'b0, 3'(i % 5)});
			settle;
			chk(ifSelect400, i > 4);
			chk(channelFilterBandwidth, bwTbl[i]);
		end
		host_u.wr(8'h00, 8'h05);
		settle;
		chk(fskDeviation, 3'h0);
		host_u.wr(8'h00, 8'h85);
		settle;
		chk({fskMode, fskDeviation}, 4'hD);
		host_u.wr(8'h10, 8'h00);
		host_u.wr(8'h13, 8'hFF);
		host_u.rd(8'h10, q);
		chk(q, 8'hA5);
		host_u.rd(8'h11, q);
		chk(q, 8'h3C);
		host_u.rd(8'h13, q);
		chk(q, 8'h00);
		host_u.rd(8'h30, q);
		chk(q, 8'h00);
		host_u.wr(8'h17, 8'h00);
		host_u.wr(8'h18, 8'h01);
		host_u.wr(8'h14, 8'h03);
		host_u.rd(8'h15, q);
		chk(q, 8'h02);
		repeat (20) @(posedge core_clk);
		host_u.rd(8'h15, q);
		chk(q, 8'h04);
		repeat (28) @(posedge core_clk);
		host_u.rd(8'h15, q);
		chk(q, 8'h02);
		chk(dataOut, 1'b1);
		host_u.wr(8'h14, 8'h01);
		host_u.wr(8'h16, 8'h01);
		host_u.wr(8'h1A, 8'h0F);
		host_u.wr(8'h17, 8'hAA);
		host_u.wr(8'h14, 8'h03);
		repeat (3) sendBit(1'b1);
		chk(dataOut, 1'b1);
		sendBit(1'b1);
		repeat (3) settle;
		chk(dataOut, 1'b0);
		host_u.rd(8'h15, q);
		chk(q, 8'h08);
		host_u.ack(q);
		chk(q, 8'h01);
		host_u.rd(8'h13, q);
		chk(q, 8'h00);
		host_u.rd(8'h15, q);
		chk(q, 8'h10);
		for (int i = 0; i < 4; i++)
		begin
			sendBit(i[0]);
			settle;
			chk(dataOut, i[0]);
		end
		repeat (4) sendBit(1'b1);
		host_u.rd(8'h13, q);
		chk(q, 8'h00);
		host_u.wr(8'h14, 8'h01);
		repeat (2) settle;
		chk(dataOut, 1'b1);
		test_done;
	end
endmodule : test_rx_config_polling_wakeup
`default_nettype wire
